//--- obc_map.svh
// Purpose: constants for the option byte configuration decoder
// Assumes: two option bytes, byte 0 and byte 1
// Notes:   bit positions, erased values and reset phase lengths
`ifndef OBC_MAP_SVH
`define OBC_MAP_SVH

`define OBC_ERASED_BYTE       8'hff
`define OBC_FACTORY_BYTE0     8'hff
`define OBC_FACTORY_BYTE1     8'hef
`define OBC_B0_WDOG_HALT      7
`define OBC_B0_WDOG_SW        6
`define OBC_B0_VD_HI          4
`define OBC_B0_VD_LO          3
`define OBC_B0_RDP            0
`define OBC_B1_PKG            7
`define OBC_B1_RESET_DELAY_SELECT           6
`define OBC_B1_OSC_HI         5
`define OBC_B1_OSC_LO         4
`define OBC_B1_RANGE_HI       3
`define OBC_B1_RANGE_LO       1
`define OBC_B1_PLL_OFF        0
`define OBC_RST_LONG_CYCLES   13'd4096
`define OBC_RST_SHORT_CYCLES  13'd256
`define OBC_PADS_PER_PORT     8

`endif

//--- obc_pkg.sv
// Purpose: types for the option byte configuration decoder
// Assumes: nothing beyond the map header
// Notes:   encodings follow the option byte fields
package obc_pkg;
  typedef enum logic [1:0] {
    OBC_VD_HIGH   = 2'h0,
    OBC_VD_MEDIUM = 2'h1,
    OBC_VD_LOWEST = 2'h2,
    OBC_VD_OFF    = 2'h3
  } obc_vd_e;

  typedef enum logic [1:0] {
    OBC_OSC_RESONATOR = 2'h0,
    OBC_OSC_RESERVED  = 2'h1,
    OBC_OSC_RC        = 2'h2,
    OBC_OSC_EXTERNAL  = 2'h3
  } obc_osc_e;

  typedef enum logic [2:0] {
    OBC_RANGE_1_2MHZ  = 3'h0,
    OBC_RANGE_2_4MHZ  = 3'h1,
    OBC_RANGE_4_8MHZ  = 3'h2,
    OBC_RANGE_8_16MHZ = 3'h3
  } obc_range_e;
endpackage : obc_pkg

//--- obc_bytes_if.sv
// Purpose: carries the two latched option bytes between modules
// Assumes: one clock domain
// Notes:   store drives, decoder reads
`timescale 1ns/1ps
interface obc_bytes_if;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic       valid;
  modport store (output byte0, output byte1, output valid);
  modport user  (input byte0, input byte1, input valid);
endinterface : obc_bytes_if

//--- obc_store.sv
// Purpose: non-volatile option byte store with programming port
// Assumes: programming mode input marks tool access
// Notes:   protected erase wipes user memory first
`timescale 1ns/1ps
`include "obc_map.svh"
module obc_store
  import obc_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       prog_mode_i,
  input  wire logic       prog_wr_i,
  input  wire logic       prog_erase_i,
  input  wire logic       prog_sel_i,
  input  wire logic [7:0] prog_wdata_i,
  input  wire logic       user_erase_done_i,
  output logic      [7:0] prog_rdata_o,
  output logic            user_erase_req_o,
  obc_bytes_if.store      bytes
);
  // store contents survive reset; factory contents select the rc clock
  logic [7:0] nv_reg [2] = '{`OBC_FACTORY_BYTE0, `OBC_FACTORY_BYTE1};
  logic       erase_pend_reg;
  logic       rdp_on;
  logic       erase_go;
  logic       wr_go;

  assign rdp_on   = ~nv_reg[0][`OBC_B0_RDP];
  assign wr_go    = prog_mode_i & prog_wr_i & ~prog_erase_i & ~erase_pend_reg;
  assign erase_go = prog_mode_i & prog_erase_i & ~erase_pend_reg;
  assign user_erase_req_o = erase_pend_reg;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      erase_pend_reg <= 1'b0;
    end else if (erase_go && rdp_on) begin
      erase_pend_reg <= 1'b1;
    end else if (user_erase_done_i) begin
      erase_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if ((erase_go && !rdp_on) || (erase_pend_reg && user_erase_done_i)) begin
      nv_reg[0] <= `OBC_ERASED_BYTE;
      nv_reg[1] <= `OBC_ERASED_BYTE;
    end else if (wr_go) begin
      nv_reg[prog_sel_i] <= nv_reg[prog_sel_i] & prog_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prog_rdata_o <= 8'h00;
    end else begin
      prog_rdata_o <= prog_mode_i ? nv_reg[prog_sel_i] : 8'h00;
    end
  end

  assign bytes.byte0 = nv_reg[0];
  assign bytes.byte1 = nv_reg[1];
  assign bytes.valid = 1'b1;

  no_read_outside_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !prog_mode_i |=> prog_rdata_o == 8'h00) else $error("option read outside prog");
  no_write_outside_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !prog_mode_i |=> nv_reg[0] == $past(nv_reg[0]) || $past(erase_pend_reg))
    else $error("option byte changed outside prog");
  erase_first_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    erase_go && rdp_on |=> erase_pend_reg && nv_reg[0] == $past(nv_reg[0]))
    else $error("protected erase skipped user wipe");
endmodule : obc_store

//--- obc_decoder.sv
// Purpose: decode option bytes into reset, clock, watchdog and flash settings
// Assumes: srst_i held until reset phase completes externally if wanted
// Notes:   values latched during reset and frozen afterwards
// Behaviour
// - option bytes reachable only in programming mode
// - erased store reads all ones
// - factory default selects internal rc clock
// - byte0 bit7 one resets on halt while watchdog active
// - byte0 bit6 zero forces watchdog on
// - byte0 bits4:3 select voltage detector threshold
// - byte0 bit0 zero enables readout protection
// - protection blocks extraction and flash writes
// - protected option erase wipes user memory first
// - byte1 bit7 selects larger package
// - unbonded pads reset as pulled-up inputs
// - byte1 bit6 picks 4096 or 256 cycles
// - byte1 bits5:4 select clock source
// - byte1 bits3:1 select frequency range
// - byte1 bit0 zero enables pll doubler
`timescale 1ns/1ps
`include "obc_map.svh"
module obc_decoder
  import obc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        prog_mode_i,
  input  wire logic        prog_wr_i,
  input  wire logic        prog_erase_i,
  input  wire logic        prog_sel_i,
  input  wire logic [7:0]  prog_wdata_i,
  input  wire logic        user_erase_done_i,
  input  wire logic        halt_entry_i,
  input  wire logic        wdog_active_i,
  input  wire logic        dbg_read_i,
  input  wire logic        flash_wr_req_i,
  output logic      [7:0]  prog_rdata_o,
  output logic             user_erase_req_o,
  output logic             wdog_reset_on_halt_o,
  output logic             wdog_hw_enable_o,
  output logic             halt_reset_o,
  output logic             low_supply_reset_detector_en_o,
  output logic             auxiliary_supply_detector_en_o,
  output logic      [1:0]  volt_detect_select_o,
  output logic             readout_protect_o,
  output logic             dbg_read_allow_o,
  output logic             flash_wr_allow_o,
  output logic             package_select_o,
  output logic      [3:0]  unbonded_port_mask_o,
  output logic             reset_delay_select_o,
  output logic      [12:0] reset_cycles_o,
  output logic      [1:0]  clock_source_type_o,
  output logic      [2:0]  clock_freq_range_o,
  output logic             pll_double_en_o,
  output logic             cfg_valid_o
);
  obc_bytes_if bytes_if ();

  logic [7:0] b0_reg;
  logic [7:0] b1_reg;
  logic       valid_reg = 1'b0;
  logic       rdp_en;

  obc_store u_store (
    .core_clk_i        (core_clk_i),
    .srst_i            (srst_i),
    .prog_mode_i       (prog_mode_i),
    .prog_wr_i         (prog_wr_i),
    .prog_erase_i      (prog_erase_i),
    .prog_sel_i        (prog_sel_i),
    .prog_wdata_i      (prog_wdata_i),
    .user_erase_done_i (user_erase_done_i),
    .prog_rdata_o      (prog_rdata_o),
    .user_erase_req_o  (user_erase_req_o),
    .bytes             (bytes_if.store)
  );

  // capture during reset, freeze afterwards
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      b0_reg    <= bytes_if.byte0;
      b1_reg    <= bytes_if.byte1;
      valid_reg <= bytes_if.valid;
    end
  end

  assign cfg_valid_o                    = valid_reg;
  assign wdog_reset_on_halt_o           = b0_reg[`OBC_B0_WDOG_HALT];
  assign halt_reset_o                   = halt_entry_i & wdog_active_i & b0_reg[`OBC_B0_WDOG_HALT];
  assign wdog_hw_enable_o               = ~b0_reg[`OBC_B0_WDOG_SW];
  assign volt_detect_select_o           = b0_reg[`OBC_B0_VD_HI:`OBC_B0_VD_LO];
  assign low_supply_reset_detector_en_o = volt_detect_select_o != OBC_VD_OFF;
  assign auxiliary_supply_detector_en_o = volt_detect_select_o != OBC_VD_OFF;
  assign rdp_en                         = ~b0_reg[`OBC_B0_RDP];
  assign readout_protect_o              = rdp_en;
  assign dbg_read_allow_o               = dbg_read_i & ~rdp_en;
  assign flash_wr_allow_o               = flash_wr_req_i & ~rdp_en;
  assign package_select_o               = b1_reg[`OBC_B1_PKG];
  // ports d and f partly unbonded on the small package stay pulled-up inputs
  assign unbonded_port_mask_o           = package_select_o ? 4'h0 : 4'h3;
  assign reset_delay_select_o           = b1_reg[`OBC_B1_RESET_DELAY_SELECT];
  assign reset_cycles_o                 = reset_delay_select_o ? `OBC_RST_SHORT_CYCLES
                                                               : `OBC_RST_LONG_CYCLES;
  assign clock_source_type_o            = b1_reg[`OBC_B1_OSC_HI:`OBC_B1_OSC_LO];
  assign clock_freq_range_o             = b1_reg[`OBC_B1_RANGE_HI:`OBC_B1_RANGE_LO];
  assign pll_double_en_o                = ~b1_reg[`OBC_B1_PLL_OFF];

  sequence halt_with_wdog_s;
    halt_entry_i && wdog_active_i;
  endsequence

  sequence in_reset_s;
    srst_i;
  endsequence

  sequence running_s;
    !srst_i;
  endsequence

  sequence tool_read_s;
    prog_mode_i;
  endsequence

  sequence tool_erase_s;
    prog_mode_i && prog_erase_i && !user_erase_req_o;
  endsequence

  sequence byte0_write_s;
    prog_mode_i && prog_wr_i && !prog_erase_i && !user_erase_req_o && !prog_sel_i;
  endsequence

  sequence wipe_finish_s;
    user_erase_req_o && user_erase_done_i;
  endsequence

  // watchdog and halt
  halt_reset_gen_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    halt_with_wdog_s |-> halt_reset_o == wdog_reset_on_halt_o)
    else $error("halt reset mismatch");
  halt_quiet_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !(halt_entry_i && wdog_active_i) |-> !halt_reset_o)
    else $error("halt reset without halt and watchdog");
  wdog_type_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wdog_hw_enable_o != b0_reg[6]) else $error("watchdog type wrong");

  // supply detectors
  vd_off_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (b0_reg[4:3] == 2'h3) == !low_supply_reset_detector_en_o)
    else $error("voltage detector enable wrong");
  aux_off_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (b0_reg[4:3] == 2'h3) == !auxiliary_supply_detector_en_o)
    else $error("auxiliary detector enable wrong");
  vd_field_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    volt_detect_select_o == b0_reg[4:3])
    else $error("voltage threshold field wrong");

  // readout protection
  rdp_block_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !b0_reg[0] |-> !flash_wr_allow_o && !dbg_read_allow_o)
    else $error("protected flash accessed");
  rdp_open_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    b0_reg[0] |-> dbg_read_allow_o == dbg_read_i && flash_wr_allow_o == flash_wr_req_i)
    else $error("unprotected access blocked");
  rdp_flag_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    readout_protect_o == !b0_reg[0])
    else $error("protection flag wrong");

  // package and reset phase
  pkg_sel_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    package_select_o == b1_reg[7]) else $error("package select wrong");
  pad_mask_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    unbonded_port_mask_o == (b1_reg[7] ? 4'h0 : 4'h3))
    else $error("unbonded pad mask wrong");
  rst_len_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    reset_cycles_o == (b1_reg[6] ? 13'd256 : 13'd4096)) else $error("reset length wrong");
  rst_sel_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    reset_delay_select_o == b1_reg[6])
    else $error("reset delay select wrong");

  // clock source
  clk_fields_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    clock_source_type_o == b1_reg[5:4] && clock_freq_range_o == b1_reg[3:1]
    && pll_double_en_o == !b1_reg[0]) else $error("clock fields wrong");

  // capture at reset, hold while running
  cfg_frozen_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !$rose(srst_i) ##1 !srst_i |-> $stable(b0_reg) && $stable(b1_reg))
    else $error("configuration changed outside reset");
  cfg_hold_a: assert property (@(posedge core_clk_i)
    running_s |=> b0_reg == $past(b0_reg) && b1_reg == $past(b1_reg))
    else $error("configuration moved while running");
  capture_a: assert property (@(posedge core_clk_i)
    in_reset_s |=> b0_reg == $past(bytes_if.byte0) && b1_reg == $past(bytes_if.byte1))
    else $error("configuration not captured in reset");
  cfg_valid_a: assert property (@(posedge core_clk_i)
    in_reset_s |=> cfg_valid_o)
    else $error("configuration not marked valid");

  // programming port and protected erase
  tool_read_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    tool_read_s |=> prog_rdata_o == $past(prog_sel_i ? bytes_if.byte1 : bytes_if.byte0))
    else $error("option read data wrong");
  write_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    byte0_write_s |=> bytes_if.byte0 == $past(bytes_if.byte0 & prog_wdata_i))
    else $error("option byte write wrong");
  wipe_start_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    tool_erase_s ##0 !bytes_if.byte0[0] |=> user_erase_req_o)
    else $error("protected erase did not request a wipe");
  erase_open_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    tool_erase_s ##0 bytes_if.byte0[0] |=> bytes_if.byte0 == 8'hff && bytes_if.byte1 == 8'hff)
    else $error("unprotected erase not immediate");
  wipe_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    user_erase_req_o && !user_erase_done_i |=> user_erase_req_o)
    else $error("wipe request dropped early");
  wipe_end_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wipe_finish_s |=> !user_erase_req_o && bytes_if.byte0 == 8'hff && bytes_if.byte1 == 8'hff)
    else $error("option bytes not erased after wipe");
endmodule : obc_decoder

//--- obc_tool_model.sv
// Purpose: programming tool and flash wipe model
// Assumes: drives at the falling clock edge
// Notes:   wipe answer delay set by wipe_cycles
`timescale 1ns/1ps
module obc_tool_model (
  input  wire logic       core_clk_i,
  input  wire logic       user_erase_req_i,
  output logic            prog_mode_o,
  output logic            prog_wr_o,
  output logic            prog_erase_o,
  output logic            prog_sel_o,
  output logic      [7:0] prog_wdata_o,
  output logic            user_erase_done_o
);
  int wipe_cycles = 2;
  initial begin
    prog_mode_o = 1'b0;
    prog_wr_o = 1'b0;
    prog_erase_o = 1'b0;
    prog_sel_o = 1'b0;
    prog_wdata_o = 8'h00;
    user_erase_done_o = 1'b0;
  end
  // one tool cycle: mode level held, strobes pulsed
  task automatic access(input logic m, input logic w, input logic e, input logic s,
                        input logic [7:0] d);
    @(negedge core_clk_i);
    prog_mode_o = m;
    prog_wr_o = w;
    prog_erase_o = e;
    prog_sel_o = s;
    prog_wdata_o = d;
    @(negedge core_clk_i);
    prog_wr_o = 1'b0;
    prog_erase_o = 1'b0;
    prog_wdata_o = ~d;
  endtask : access
  // flash answers a wipe request after a delay
  always begin
    @(negedge core_clk_i);
    if (user_erase_req_i === 1'b1) begin
      repeat (wipe_cycles) @(negedge core_clk_i);
      user_erase_done_o = 1'b1;
      @(negedge core_clk_i);
      user_erase_done_o = 1'b0;
    end
  end
endmodule : obc_tool_model

//--- testbench.sv
// Purpose: self-checking bench for the option byte decoder
// Assumes: factory store ff/ef, values frozen at reset
// Notes:   reserved bits always written as one
`timescale 1ns/1ps
module testbench;
  import obc_pkg::*;
  logic        core_clk_i, srst_i, halt_i, wdog_i, dbg_i, fwr_i;
  logic        mode, wr, er, sel, done, req, roh, hwen, hrst, low_supply_reset_detector, auxiliary_supply_detector, rdp;
  logic        dbg_ok, fw_ok, pkg, rsel, pll, cfg_valid;
  logic [7:0]  wdata, rdata;
  logic [1:0]  vd, osc;
  logic [2:0]  rng;
  logic [3:0]  mask;
  logic [12:0] rcyc;
  int          fails = 0;
  int          compares = 0;
  obc_decoder i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .prog_mode_i(mode),
    .prog_wr_i(wr), .prog_erase_i(er), .prog_sel_i(sel), .prog_wdata_i(wdata),
    .user_erase_done_i(done), .halt_entry_i(halt_i), .wdog_active_i(wdog_i),
    .dbg_read_i(dbg_i), .flash_wr_req_i(fwr_i), .prog_rdata_o(rdata),
    .user_erase_req_o(req), .wdog_reset_on_halt_o(roh), .wdog_hw_enable_o(hwen),
    .halt_reset_o(hrst), .low_supply_reset_detector_en_o(low_supply_reset_detector),
    .auxiliary_supply_detector_en_o(auxiliary_supply_detector), .volt_detect_select_o(vd),
    .readout_protect_o(rdp), .dbg_read_allow_o(dbg_ok), .flash_wr_allow_o(fw_ok),
    .package_select_o(pkg), .unbonded_port_mask_o(mask), .reset_delay_select_o(rsel),
    .reset_cycles_o(rcyc), .clock_source_type_o(osc), .clock_freq_range_o(rng),
    .pll_double_en_o(pll), .cfg_valid_o(cfg_valid));
  obc_tool_model i_tool (.core_clk_i(core_clk_i), .user_erase_req_i(req),
    .prog_mode_o(mode), .prog_wr_o(wr), .prog_erase_o(er), .prog_sel_o(sel),
    .prog_wdata_o(wdata), .user_erase_done_o(done));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic test_done;
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic do_reset;
    @(negedge core_clk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    srst_i = 1'b0;
  endtask : do_reset
  task automatic rd(input logic s, input logic [7:0] exp);
    i_tool.access(1'b1, 1'b0, 1'b0, s, 8'h00);
    cmp("rdata", 16'(exp), 16'(rdata));
  endtask : rd
  // decoded outputs against the bytes expected to be frozen
  task automatic check_cfg(input logic [7:0] b0, input logic [7:0] b1);
    i_tool.access(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    cmp("rdata off", 16'h0001, 16'({rdata, cfg_valid}));
    cmp("wdog", 16'({b0[7], b0[7], ~b0[6]}), 16'({roh, hrst, hwen}));
    cmp("vd", 16'({b0[4:3], {2{b0[4:3] != 2'h3}}}), 16'({vd, low_supply_reset_detector, auxiliary_supply_detector}));
    cmp("rdp", 16'({~b0[0], b0[0], b0[0]}), 16'({rdp, dbg_ok, fw_ok}));
    cmp("pkg", 16'({b1[7], b1[7] ? 4'h0 : 4'h3}), 16'({pkg, mask}));
    cmp("reset_delay_select", 16'({b1[6], b1[6] ? 13'd256 : 13'd4096}), 16'({rsel, rcyc}));
    cmp("clk", 16'({b1[5:1], ~b1[0]}), 16'({osc, rng, pll}));
    halt_i = 1'b0;
    fwr_i  = 1'b0;
    @(negedge core_clk_i);
    cmp("gate a", 16'h0000, 16'({hrst, fw_ok}));
    halt_i = 1'b1;
    fwr_i  = 1'b1;
    wdog_i = 1'b0;
    dbg_i  = 1'b0;
    @(negedge core_clk_i);
    cmp("gate b", 16'h0000, 16'({hrst, dbg_ok}));
    wdog_i = 1'b1;
    dbg_i  = 1'b1;
  endtask : check_cfg
  task automatic t_factory;
    do_reset();
    check_cfg(8'hff, 8'hef);
    rd(1'b0, 8'hff);
    rd(1'b1, 8'hef);
  endtask : t_factory
  // resonator, long delay, doubler at 2 to 4 mhz, protection on
  task automatic t_program;
    i_tool.access(1'b1, 1'b1, 1'b0, 1'b0, 8'h6e);
    i_tool.access(1'b1, 1'b1, 1'b0, 1'b1, 8'h02);
    rd(1'b0, 8'h6e);
    rd(1'b1, 8'h02);
    i_tool.access(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
    check_cfg(8'hff, 8'hef);
    do_reset();
    check_cfg(8'h6e, 8'h02);
    rd(1'b0, 8'h6e);
  endtask : t_program
  task automatic t_erase;
    int n;
    i_tool.wipe_cycles = 12;
    i_tool.access(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    n = 0;
    while (req !== 1'b1 && n < 3) begin
      @(negedge core_clk_i);
      n++;
    end
    cmp("wipe req", 16'h0001, 16'(req));
    i_tool.access(1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
    n = 0;
    while (req !== 1'b0 && n < 30) begin
      @(negedge core_clk_i);
      n++;
    end
    cmp("wipe end", 16'h0000, 16'(req));
    rd(1'b0, 8'hff);
    rd(1'b1, 8'hff);
    check_cfg(8'h6e, 8'h02);
    do_reset();
    check_cfg(8'hff, 8'hff);
  endtask : t_erase
  // remaining threshold and source codes, range codes 3 and 7
  task automatic t_codes;
    logic [7:0] c0 [2] = '{8'hf7, 8'he7};
    logic [7:0] c1 [2] = '{8'hdf, 8'hd7};
    for (int i = 0; i < 2; i++) begin
      i_tool.access(1'b1, 1'b1, 1'b0, 1'b0, c0[i]);
      i_tool.access(1'b1, 1'b1, 1'b0, 1'b1, c1[i]);
      do_reset();
      check_cfg(c0[i], c1[i]);
    end
    i_tool.access(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    cmp("no wipe", 16'h0000, 16'(req));
    rd(1'b0, 8'hff);
    rd(1'b1, 8'hff);
  endtask : t_codes
  initial begin
    srst_i = 1'b1;
    halt_i = 1'b1;
    wdog_i = 1'b1;
    dbg_i = 1'b1;
    fwr_i = 1'b1;
    t_factory();
    t_program();
    t_erase();
    t_codes();
    test_done();
  end
  initial begin
    #20000;
    fails++;
    test_done();
  end
endmodule : testbench
